// file: core/maa_pkg.sv
// Package of constants for the memory access arbiter
//------------------------------------------------------------------------------
//------------------------------------------------------------------------------
package maa_pkg;
  localparam logic [7:0] UNLOCK_KEY1   = 8'h55;
  localparam logic [7:0] UNLOCK_KEY2   = 8'hAA;
  localparam int         LOCK_FLAG_BIT = 0;
  localparam int         MEM_SEL_W     = 2;
  localparam int         PRIO_W        = 3;
  localparam logic [2:0] PRIO_RST_ISR  = 3'h2;
  localparam logic [2:0] PRIO_RST_MAIN = 3'h1;
  localparam logic [2:0] PRIO_RST_PER  = 3'h0;

  typedef enum logic [1:0] {
    MAA_MEM_FLASH,
    MAA_MEM_RAM,
    MAA_MEM_EEPROM
  } maa_mem_t;

  typedef enum {
    MAA_SEQ_IDLE,
    MAA_SEQ_KEY1,
    MAA_SEQ_OPEN
  } maa_seq_t;
endpackage

// file: core/maa_lock.sv
// Lock register with its unlock key sequence
`timescale 1ns/10ps
module maa_lock (
  input  wire logic       ref_clk_i,
  input  wire logic       rst_n_i,
  input  wire logic       clk_en_i,
  input  wire logic       lock_wr_i,
  input  wire logic [7:0] lock_wdata_i,
  output logic            lock_flag_o
);
  maa_pkg::maa_seq_t seq_ff;
  maa_pkg::maa_seq_t nxt_seq;
  logic              flag_ff;
  logic              nxt_flag;

  always_comb begin
    nxt_seq  = seq_ff;
    nxt_flag = flag_ff;
    if (lock_wr_i) begin
      case (seq_ff)
        maa_pkg::MAA_SEQ_IDLE: begin
          nxt_seq = (lock_wdata_i == maa_pkg::UNLOCK_KEY1) ?
                    maa_pkg::MAA_SEQ_KEY1 : maa_pkg::MAA_SEQ_IDLE;
        end
        maa_pkg::MAA_SEQ_KEY1: begin
          // A repeated first key counts as a fresh start
          if (lock_wdata_i == maa_pkg::UNLOCK_KEY2) begin
            nxt_seq = maa_pkg::MAA_SEQ_OPEN;
          end else if (lock_wdata_i == maa_pkg::UNLOCK_KEY1) begin
            nxt_seq = maa_pkg::MAA_SEQ_KEY1;
          end else begin
            nxt_seq = maa_pkg::MAA_SEQ_IDLE;
          end
        end
        maa_pkg::MAA_SEQ_OPEN: begin
          nxt_flag = lock_wdata_i[maa_pkg::LOCK_FLAG_BIT];
          nxt_seq  = maa_pkg::MAA_SEQ_IDLE;
        end
        default: nxt_seq = maa_pkg::MAA_SEQ_IDLE;
      endcase
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      seq_ff  <= maa_pkg::MAA_SEQ_IDLE;
      flag_ff <= 1'b0;
    end else if (clk_en_i) begin
      seq_ff  <= nxt_seq;
      flag_ff <= nxt_flag;
    end
  end

  assign lock_flag_o = flag_ff;
endmodule

// file: core/maa_arbiter.sv
// Memory access arbiter between CPU main code, CPU interrupt code and peripherals
`timescale 1ns/10ps
module maa_arbiter #(
  parameter int N_PER = 2
) (
  input  wire logic                        ref_clk_i,
  input  wire logic                        rst_n_i,
  input  wire logic                        clk_en_i,
  // Lock register write port
  input  wire logic                        lock_wr_i,
  input  wire logic [7:0]                  lock_wdata_i,
  output logic                             priority_lock_flag_o,
  // Priority settings write port
  input  wire logic                        prio_wr_i,
  input  wire logic [maa_pkg::PRIO_W-1:0]  prio_isr_i,
  input  wire logic [maa_pkg::PRIO_W-1:0]  prio_main_i,
  input  wire logic [maa_pkg::PRIO_W-1:0]  prio_per_i,
  output logic [maa_pkg::PRIO_W-1:0]       prio_isr_o,
  output logic [maa_pkg::PRIO_W-1:0]       prio_main_o,
  output logic [maa_pkg::PRIO_W-1:0]       prio_per_o,
  // CPU side, one instruction cycle per enabled clock
  input  wire logic                        cpu_in_isr_i,
  input  wire logic                        cpu_flash_use_i,
  input  wire logic                        cpu_ram_use_i,
  input  wire logic                        cpu_eeprom_use_i,
  input  wire logic                        flash_op_busy_i,
  input  wire logic                        eeprom_op_busy_i,
  output logic                             cpu_stall_o,
  // Peripheral masters
  input  wire logic [N_PER-1:0]            per_req_i,
  input  wire logic [N_PER-1:0]            per_done_i,
  input  wire logic [N_PER-1:0]            per_disable_req_i,
  input  wire logic [2*N_PER-1:0]          per_mem_i,
  output logic [N_PER-1:0]                 per_gnt_o,
  output logic [N_PER-1:0]                 per_enable_o
);
  //----------------------------------------------------------------------------
  // Lock register
  //----------------------------------------------------------------------------
  // Key tracking lives in its own module; only the resulting flag is used here
  logic                       lock_flag;

  maa_lock u_lock (
    .ref_clk_i    (ref_clk_i),
    .rst_n_i      (rst_n_i),
    .clk_en_i     (clk_en_i),
    .lock_wr_i    (lock_wr_i),
    .lock_wdata_i (lock_wdata_i),
    .lock_flag_o  (lock_flag)
  );

  //----------------------------------------------------------------------------
  // Priority registers
  //----------------------------------------------------------------------------
  // Writes while locked are dropped without any error indication; software
  // reads the settings back when it needs to know they were taken.
  logic [maa_pkg::PRIO_W-1:0] isr_ff;
  logic [maa_pkg::PRIO_W-1:0] main_ff;
  logic [maa_pkg::PRIO_W-1:0] per_ff;
  logic [maa_pkg::PRIO_W-1:0] nxt_isr;
  logic [maa_pkg::PRIO_W-1:0] nxt_main;
  logic [maa_pkg::PRIO_W-1:0] nxt_per;

  always_comb begin
    nxt_isr  = isr_ff;
    nxt_main = main_ff;
    nxt_per  = per_ff;
    if (prio_wr_i && !lock_flag) begin
      nxt_isr  = prio_isr_i;
      nxt_main = prio_main_i;
      nxt_per  = prio_per_i;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      isr_ff  <= maa_pkg::PRIO_RST_ISR;
      main_ff <= maa_pkg::PRIO_RST_MAIN;
      per_ff  <= maa_pkg::PRIO_RST_PER;
    end else if (clk_en_i) begin
      isr_ff  <= nxt_isr;
      main_ff <= nxt_main;
      per_ff  <= nxt_per;
    end
  end

  //----------------------------------------------------------------------------
  // Running priority
  //----------------------------------------------------------------------------
  // Software keeps ISR above main only the running context's
  // priority is compared, so mixed settings fall back to the active one.
  // Context switches take effect in the same cycle, like the grants.
  logic                       per_high;
  logic [maa_pkg::PRIO_W-1:0] cpu_prio;

  always_comb begin
    if (cpu_in_isr_i) begin
      cpu_prio = isr_ff;
    end else begin
      cpu_prio = main_ff;
    end
    // Ties go to the CPU, so equal settings never stall it
    per_high = per_ff > cpu_prio;
  end

  //----------------------------------------------------------------------------
  // Per-peripheral slot check and disable hold
  //----------------------------------------------------------------------------
  // Each peripheral looks at its own target, the CPU's use of it and any busy flag of that memory, unless per_high frees every target
  logic [N_PER-1:0] free_ok;
  logic [N_PER-1:0] enable;
  logic [N_PER-1:0] gnt;
  logic [N_PER-1:0] held;
  logic             held_any;
  logic [N_PER-1:0] owner_ff;
  logic [N_PER-1:0] nxt_owner;

  genvar g;
  generate
    for (g = 0; g < N_PER; g++) begin : g_per
      logic [maa_pkg::MEM_SEL_W-1:0] mem;
      logic                          slot_ok;

      assign mem = per_mem_i[g*maa_pkg::MEM_SEL_W +: maa_pkg::MEM_SEL_W];

      always_comb begin
        slot_ok = 1'b0;
        if (per_high) begin
          // The CPU is held instead, so every target counts as free
          slot_ok = 1'b1;
        end else begin
          // Only cycles the CPU leaves unused, so it never slows
          case (mem)
            maa_pkg::MAA_MEM_FLASH: begin
              // A running self-timed flash operation also blocks the slot
              slot_ok = !cpu_flash_use_i && !flash_op_busy_i;
            end
            maa_pkg::MAA_MEM_RAM: begin
              slot_ok = !cpu_ram_use_i;
            end
            maa_pkg::MAA_MEM_EEPROM: begin
              slot_ok = !cpu_eeprom_use_i && !eeprom_op_busy_i;
            end
            default: begin
              // A target with no memory behind it only runs while CPU is held
              slot_ok = 1'b0;
            end
          endcase
        end
      end

      assign free_ok[g] = slot_ok;
      // An owning high-priority peripheral ignores disable requests
      assign enable[g]  = !per_disable_req_i[g] || owner_ff[g];
    end
  endgenerate

  //----------------------------------------------------------------------------
  // Grant decision
  //----------------------------------------------------------------------------
  assign held     = owner_ff & per_req_i;
  assign held_any = |held;

  // Fixed order among peripherals: a held owner keeps the bus, else the
  // lowest index wins; a busy low index can starve the others.
  always_comb begin
    gnt = '0;
    if (lock_flag) begin
      if (held_any) begin
        gnt = held & free_ok;
      end else begin
        // Scan downward so the lowest requesting index is written last
        for (int i = N_PER - 1; i >= 0; i--) begin
          if (per_req_i[i] && free_ok[i]) begin
            // Only one grant is ever raised; earlier picks are cleared
            gnt    = '0;
            gnt[i] = 1'b1;
          end
        end
      end
    end
  end

  //----------------------------------------------------------------------------
  // Bus ownership
  //----------------------------------------------------------------------------
  // A high-priority winner keeps the bus until it reports done or drops its
  // request; clearing the lock releases every owner at once.
  // Owners are only ever recorded in the high-priority case.
  always_comb begin
    nxt_owner = held & ~per_done_i;
    if (!lock_flag) begin
      nxt_owner = '0;
    end else if (!held_any && per_high) begin
      nxt_owner = gnt & ~per_done_i;
    end
  end

  // Owners freeze with the enable like every other register
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      owner_ff <= '0;
    end else if (clk_en_i) begin
      owner_ff <= nxt_owner;
    end
  end

  //----------------------------------------------------------------------------
  // Outputs
  //----------------------------------------------------------------------------
  // Grants and stall stay combinational so a peripheral can use the very
  // cycle the CPU leaves free; a registered grant would always be late.
  assign per_gnt_o            = gnt;
  // The CPU waits only while a high-priority grant is live, so a finished
  // owner releases it in the same cycle its request drops.
  assign cpu_stall_o          = per_high && (|gnt);
  assign per_enable_o         = enable;
  // Flag and settings are read back straight from their registers
  assign priority_lock_flag_o = lock_flag;
  assign prio_isr_o           = isr_ff;
  assign prio_main_o          = main_ff;
  assign prio_per_o           = per_ff;
endmodule

// file: dv/maa_arbiter_assertions.sv
// Concurrent checks on the arbiter ports
`timescale 1ns/10ps
module maa_chk #(parameter int N_PER = 2) (
  input wire logic ref_clk_i, rst_n_i, clk_en_i, lock_wr_i, prio_wr_i,
  input wire logic cpu_in_isr_i, cpu_flash_use_i, flash_op_busy_i,
  input wire logic cpu_eeprom_use_i, eeprom_op_busy_i, cpu_stall_o,
  input wire logic priority_lock_flag_o,
  input wire logic [7:0] lock_wdata_i,
  input wire logic [2:0] prio_isr_i, prio_isr_o, prio_main_o, prio_per_o,
  input wire logic [N_PER-1:0] per_req_i, per_gnt_o, per_done_i,
  input wire logic [N_PER-1:0] per_enable_o,
  input wire logic [2*N_PER-1:0] per_mem_i
);
  logic fl, lo;
  assign fl = priority_lock_flag_o;
  assign lo = prio_per_o <= (cpu_in_isr_i ? prio_isr_o : prio_main_o);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);
  sequence s_wr(v);
    lock_wr_i && clk_en_i && lock_wdata_i == v;
  endsequence
  sequence s_key;
    s_wr(8'h55) ##1 s_wr(8'hAA) ##1 lock_wr_i && clk_en_i;
  endsequence
  a_key_sets:
    assert property (s_key |=> {7'h0, fl} == ($past(lock_wdata_i) & 8'h01))
    else $error("flag not taken from key write");
  a_flag_hold:
    assert property (!(lock_wr_i && clk_en_i) |=> $stable(fl))
    else $error("flag moved without a write");
  a_no_lock_gnt:
    assert property (!fl |-> per_gnt_o == '0) else $error("grant unlocked");
  a_prio_frozen:
    assert property (fl |=> $stable({prio_isr_o, prio_main_o, prio_per_o}))
    else $error("priority moved while locked");
  a_prio_takes:
    assert property (prio_wr_i && clk_en_i && !fl |=>
      prio_isr_o == $past(prio_isr_i)) else $error("priority not written");
  a_low_flash:
    assert property (fl && lo && per_gnt_o[0] && per_mem_i[1:0] == 2'h0 |->
      !cpu_flash_use_i && !flash_op_busy_i) else $error("flash taken");
  a_low_eeprom:
    assert property (fl && lo && per_req_i[0] && per_mem_i[1:0] == 2'h2 &&
      !cpu_eeprom_use_i && !eeprom_op_busy_i |-> per_gnt_o[0])
    else $error("free eeprom not granted");
  a_low_no_stall:
    assert property (lo |-> !cpu_stall_o) else $error("stall in low case");
  a_high_stall:
    assert property (!lo && per_gnt_o != '0 |-> cpu_stall_o)
    else $error("high grant without stall");
  a_owner_kept:
    assert property (fl && !lo && per_gnt_o[0] && clk_en_i && !per_done_i[0]
      ##1 fl && per_req_i[0] && !per_done_i[0] |-> per_enable_o[0])
    else $error("owner disabled");
endmodule

// file: dv/maa_per_model.sv
// Peripheral bus masters that request memory and finish after service
`timescale 1ns/10ps
module maa_per_model (
  input  wire logic       clk_i,
  input  wire logic       rst_n_i,
  input  wire logic [1:0] gnt_i,
  output logic      [1:0] req_o  = 2'h0,
  output logic      [1:0] done_o = 2'h0,
  output logic      [3:0] mem_o  = 4'h0
);
  int left [2];
  // Target wanders while idle so a stale value is never trusted
  always @(posedge clk_i)
    for (int i = 0; i < 2; i++) begin
      if (!rst_n_i || !req_o[i]) begin
        req_o[i] <= rst_n_i && $urandom % 4 == 0;
        mem_o[2*i+:2] <= 2'($urandom % 4);
        left[i] = $urandom % 4;
      end else if (gnt_i[i] && --left[i] < 0)
        req_o[i] <= 1'b0;
      done_o[i] <= rst_n_i && req_o[i] && gnt_i[i] && left[i] < 0;
    end
endmodule

// file: dv/tb.sv
// Self-checking bench for the memory access arbiter
`timescale 1ns/10ps
module tb;
  logic       clk = 0, rst_n = 0, en = 1, lw = 0, pw = 0, isr = 0;
  logic       cf = 0, cr = 0, ce = 0, fb = 0, eb = 0, stall, fo, fl, hi;
  logic [7:0] wd = 8'h00;
  logic [2:0] pi = 3'h0, pm = 3'h0, pp = 3'h0, qi, qm, qp, mi, mm, mp;
  logic [1:0] req, done, gnt, ena, eg, ee, sq, dis = 2'h0;
  logic [3:0] mem;
  int         miscompares, cmp_count, own;
  always #25 clk = ~clk;
  maa_arbiter #(.N_PER(2)) i_dut (.ref_clk_i(clk), .rst_n_i(rst_n),
    .clk_en_i(en), .lock_wr_i(lw), .lock_wdata_i(wd),
    .priority_lock_flag_o(fo), .prio_wr_i(pw), .prio_isr_i(pi),
    .prio_main_i(pm), .prio_per_i(pp), .prio_isr_o(qi), .prio_main_o(qm),
    .prio_per_o(qp), .cpu_in_isr_i(isr), .cpu_flash_use_i(cf),
    .cpu_ram_use_i(cr), .cpu_eeprom_use_i(ce), .flash_op_busy_i(fb),
    .eeprom_op_busy_i(eb), .cpu_stall_o(stall), .per_req_i(req),
    .per_done_i(done), .per_disable_req_i(dis), .per_mem_i(mem),
    .per_gnt_o(gnt), .per_enable_o(ena));
  maa_per_model i_per (.clk_i(clk), .rst_n_i(rst_n), .gnt_i(gnt),
    .req_o(req), .done_o(done), .mem_o(mem));
  task automatic chk(input string n, input logic [8:0] s, e);
    cmp_count++;
    if (s !== e) begin
      miscompares++;
      $display("CHECK FAILED %s exp %h seen %h", n, e, s);
    end
  endtask
  task automatic results;
    $display("compares %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic wr(input logic [7:0] v);
    lw <= 1;
    wd <= v;
    @(posedge clk);
  endtask
  task automatic run(input int n);
    lw <= 0;
    repeat (n) begin
      {isr, cf, cr, ce, fb, eb, dis} <= 8'($urandom);
      en <= $urandom % 8 != 0;
      @(posedge clk);
    end
    en <= 1;
  endtask
  // Reference grant, judged once inputs have settled
  always @(negedge clk) if (rst_n) begin
    hi = mp > (isr ? mi : mm);
    eg = 2'h0;
    for (int i = 1; i >= 0; i--)
      if (req[i] && (hi || (mem[2*i+:2] == 0 ? !cf && !fb :
          mem[2*i+:2] == 1 ? !cr : mem[2*i+:2] == 2 && !ce && !eb)))
        eg = 2'h1 << i;
    if (hi && own >= 0 && req[own]) eg = 2'h1 << own;
    if (!fl) eg = 2'h0;
    chk("grant", gnt, eg);
    chk("stall", stall, hi && eg != 0);
    chk("flag", fo, fl);
    chk("prio", {qi, qm, qp}, {mi, mm, mp});
    ee = ~dis | (own >= 0 ? 2'h1 << own : 2'h0);
    chk("enable", ena, ee);
  end
  always @(posedge clk)
    if (!rst_n) begin
      {fl, sq, mi, mm, mp, own} = {3'h0, 3'h2, 3'h1, 3'h0, -32'sd1};
    end else if (en) begin
      if (own >= 0 && (!req[own] || done[own])) own = -1;
      if (hi && eg != 0 && own < 0) own = int'(eg[1]);
      if (!fl) own = -1;
      if (pw && !fl) {mi, mm, mp} = {pi, pm, pp};
      if (lw && sq == 2) {fl, sq} = {wd[0], 2'h0};
      else if (lw) sq = wd == 8'h55 ? 2'h1 : sq == 1 && wd == 8'hAA ? 2'h2 : 2'h0;
    end
  initial begin
    void'($urandom(32'h317a));
    repeat (2) @(posedge clk);
    rst_n <= 1;
    {pi, pm, pp, pw} <= {3'h5, 3'h3, 3'h1, 1'b1};
    @(posedge clk);
    pw <= 0;
    wr(8'h55); wr(8'h00); wr(8'hAA); wr(8'h01);
    wr(8'h55); wr(8'h55); wr(8'hAA); wr(8'h01);
    run(400);
    $display("test low priority done");
    {pi, pw} <= {3'h6, 1'b1};
    @(posedge clk);
    wr(8'h55); wr(8'hAA); wr(8'h00);
    {lw, pp, pw} <= {1'b0, 3'h7, 1'b1};
    @(posedge clk);
    pw <= 0;
    wr(8'h55); wr(8'hAA); wr(8'h01);
    run(400);
    $display("test high priority done");
    wr(8'h55); wr(8'hAA); wr(8'h00);
    run(50);
    $display("test unlocked done");
    results;
  end
  initial begin
    repeat (5000) @(posedge clk);
    miscompares++;
    results;
  end
endmodule
bind maa_arbiter maa_chk #(.N_PER(N_PER)) i_chk (
  .ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .clk_en_i(clk_en_i),
  .lock_wr_i(lock_wr_i), .lock_wdata_i(lock_wdata_i),
  .prio_wr_i(prio_wr_i), .prio_isr_i(prio_isr_i),
  .priority_lock_flag_o(priority_lock_flag_o), .prio_isr_o(prio_isr_o),
  .prio_main_o(prio_main_o), .prio_per_o(prio_per_o),
  .cpu_in_isr_i(cpu_in_isr_i), .cpu_flash_use_i(cpu_flash_use_i),
  .flash_op_busy_i(flash_op_busy_i), .cpu_eeprom_use_i(cpu_eeprom_use_i),
  .eeprom_op_busy_i(eeprom_op_busy_i), .cpu_stall_o(cpu_stall_o),
  .per_req_i(per_req_i), .per_gnt_o(per_gnt_o), .per_done_i(per_done_i),
  .per_enable_o(per_enable_o), .per_mem_i(per_mem_i));
